// ### bench/qsfc_flash_model.sv
// Purpose: Behavioural serial flash that streams read data.
// Assumes: Data launched on sclk fall, stable until next fall.
// Notes:   Lines toggle every cycle while deselected.
`timescale 1ns/1ps

module qsfc_flash_model (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_sclk,
  input  wire logic                  i_cs_n,
  input  wire qsfc_pkg::qsfc_lanes_e i_lanes,
  input  wire logic [511:0]          i_stream,
  output logic      [3:0]            o_d
);
  import qsfc_pkg::*;

  int ptr = 0;
  int w;

  initial o_d = 4'h0;
  assign w = (i_lanes == LANES_4) ? 4 : ((i_lanes == LANES_2) ? 2 : 1);

  // Higher line carries the earlier stream bit
  task automatic present();
    for (int k = 0; k < 4; k++) begin
      o_d[k] = i_stream[(ptr + ((k < w) ? w - 1 - k : 0)) % 512];
    end
  endtask : present

  always @(negedge i_cs_n) begin
    ptr = 0;
    present();
  end
  always @(negedge i_sclk) if (!i_cs_n) begin
    ptr = ptr + w;
    present();
  end
  always @(negedge i_core_clk) if (i_cs_n) o_d <= ~o_d;
endmodule : qsfc_flash_model

// ### bench/qsfc_top_sva.sv
// Purpose: Concurrent checks on the serial pins and status pulses.
// Assumes: Configuration held stable through a frame.
// Notes:   Sees only the top module ports; bound below.
`timescale 1ns/1ps

module qsfc_top_sva (
  input wire logic                       i_core_clk,
  input wire logic                       i_reset_n,
  input wire logic                       i_start,
  input wire logic [qsfc_pkg::DIV_W-1:0] i_serial_clock_divider_value,
  input wire logic [qsfc_pkg::DLY_W-1:0] i_cs_to_data_delay_field,
  input wire logic                       o_busy,
  input wire logic                       o_rd_valid,
  input wire logic                       o_word_irq,
  input wire logic                       o_frame_irq,
  input wire logic                       o_sclk,
  input wire logic                       o_cs_n,
  input wire logic [3:0]                 o_d_out,
  input wire logic [3:0]                 o_d_oe
);
  import qsfc_pkg::*;

  // ==========================================================================
  // Interval counters
  logic        sclk_q_ff, cs_q_ff, oe_q_ff, first_ff, nxt_first, fall_w, cs_fall_w;
  logic [15:0] fall_cnt_ff, cs_cnt_ff, oe_cnt_ff, hi_cnt_ff;
  logic [15:0] nxt_fall_cnt, nxt_cs_cnt, nxt_oe_cnt, nxt_hi_cnt;
  int          per;

  assign fall_w    = sclk_q_ff & ~o_sclk;
  assign cs_fall_w = cs_q_ff & ~o_cs_n;
  assign per       = ((i_serial_clock_divider_value == '0) ? 1 : int'(i_serial_clock_divider_value)) + 1;

  always_comb begin
    nxt_fall_cnt = fall_w ? 16'h1 : fall_cnt_ff + 16'h1;
    nxt_cs_cnt   = cs_fall_w ? 16'h1 : cs_cnt_ff + 16'h1;
    nxt_oe_cnt   = (o_d_oe[0] & ~oe_q_ff) ? 16'h1 : oe_cnt_ff + 16'h1;
    nxt_hi_cnt   = o_sclk ? hi_cnt_ff + 16'h1 : 16'h0;
    nxt_first    = cs_fall_w | (first_ff & ~fall_w);
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {sclk_q_ff, cs_q_ff, oe_q_ff, first_ff} <= 4'h4;
      {fall_cnt_ff, cs_cnt_ff, oe_cnt_ff, hi_cnt_ff} <= 64'h0;
    end else begin
      {sclk_q_ff, cs_q_ff, oe_q_ff, first_ff} <= {o_sclk, o_cs_n, o_d_oe[0], nxt_first};
      {fall_cnt_ff, cs_cnt_ff, oe_cnt_ff, hi_cnt_ff} <= {nxt_fall_cnt, nxt_cs_cnt, nxt_oe_cnt, nxt_hi_cnt};
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  a_sclk_idle_low: assert property (o_cs_n |-> !o_sclk) else $error("sclk high while deselected");
  a_idle_quiet: assert property (!o_busy |-> o_cs_n && !o_d_oe[0]) else $error("pins active when idle");
  a_busy_on_start: assert property (!o_busy && i_start |=> o_busy) else $error("start not taken");
  a_word_irq_pair: assert property (o_word_irq |-> o_rd_valid) else $error("word irq without data");
  a_valid_on_fall: assert property (o_rd_valid |-> $fell(o_sclk) && !o_cs_n) else $error("data off fall");
  a_frame_irq_end: assert property (o_frame_irq |-> $rose(o_cs_n)) else $error("frame irq off end");
  a_data_on_fall: assert property ($changed(o_d_out) |-> !o_sclk) else $error("data moved with sclk high");
  a_cs_lead_time: assert property (fall_w && first_ff |->
    int'(cs_cnt_ff) == (int'(i_cs_to_data_delay_field) + 1) * per) else $error("cs lead wrong");
  a_cs_lag_time: assert property ($rose(o_cs_n) |-> int'(fall_cnt_ff) == 2 * per) else $error("cs lag wrong");
  a_sclk_high_len: assert property (fall_w |-> int'(hi_cnt_ff) == per / 2) else $error("sclk high time wrong");
  a_oe_lead_cs: assert property ($fell(o_cs_n) && o_d_oe[0] |-> int'(oe_cnt_ff) == per) else $error("oe lead");

  c_frame_end: cover property (o_frame_irq);
  c_word_irq: cover property (o_word_irq);
  c_long_lead: cover property (fall_w && first_ff && i_cs_to_data_delay_field == 2'h3);
endmodule : qsfc_top_sva

bind qsfc_top qsfc_top_sva u_sva (.i_core_clk, .i_reset_n, .i_start, .i_serial_clock_divider_value,
  .i_cs_to_data_delay_field, .o_busy, .o_rd_valid, .o_word_irq, .o_frame_irq, .o_sclk, .o_cs_n, .o_d_out, .o_d_oe);

// ### bench/tb.sv
// Purpose: Self-checking bench for the quad serial flash controller.
// Assumes: Flash model launches bits on falling sclk.
// Notes:   Driver queues expected words; monitor pops on each valid.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t got %h exp %h", $time, (a), (b)); end end

module tb;
  import qsfc_pkg::*;

  logic                 i_core_clk = 1'b0;
  logic                 i_reset_n = 1'b0;
  logic                 i_start = 1'b0;
  logic [DIV_W-1:0]     i_serial_clock_divider_value = '0;
  logic [LEN_W-1:0]     i_word_len_m1 = '0;
  logic [CNT_W-1:0]     i_word_count_m1 = '0;
  logic [DLY_W-1:0]     i_cs_to_data_delay_field = '0;
  qsfc_lanes_e          i_lanes = LANES_1;
  qsfc_pins_e           i_pins = PINS_4;
  logic                 i_write_en = 1'b0;
  logic [127:0]         i_tx_word = '0;
  logic                 i_word_irq_en = 1'b0;
  logic                 i_frame_irq_en = 1'b0;
  logic                 o_busy, o_rd_valid, o_word_irq, o_frame_irq, o_sclk, o_cs_n;
  logic [127:0]         o_rd_data, exp_w, tx_msk;
  logic [127:0]         tx_cap = '0;
  logic [3:0]           o_d_out, o_d_oe, flash_d, i_d_in;
  logic [511:0]         stream = '0;
  logic [127:0]         exp_q[$];
  int                   checks = 0;
  int                   mismatches = 0;
  int                   frame_irqs = 0;
  int                   cycles = 0;
  integer               seed = 32'h62d3;

  always #2 i_core_clk = ~i_core_clk;
  assign i_d_in = {flash_d[3:1], o_d_oe[0] ? o_d_out[0] : flash_d[0]};

  qsfc_top dut (.i_core_clk, .i_reset_n, .i_start, .i_serial_clock_divider_value, .i_word_len_m1,
    .i_word_count_m1, .i_cs_to_data_delay_field, .i_lanes, .i_pins, .i_write_en, .i_tx_word, .i_word_irq_en,
    .i_frame_irq_en, .o_busy, .o_rd_data, .o_rd_valid, .o_word_irq, .o_frame_irq, .o_sclk, .o_cs_n,
    .o_d_out, .o_d_oe, .i_d_in);

  qsfc_flash_model u_flash (.i_core_clk, .i_sclk(o_sclk), .i_cs_n(o_cs_n), .i_lanes, .i_stream(stream),
    .o_d(flash_d));

  // ==========================================================================
  // Verdict and watchdog
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Output monitor
  // Far side takes d0 on each rising sclk; the last len bits form the word sent
  always @(posedge o_sclk) tx_cap = {tx_cap[126:0], o_d_out[0]};

  always @(negedge i_core_clk) begin
    if (o_rd_valid === 1'b1) begin
      `CHK(exp_q.size() > 0, 1'b1)
      exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
      `CHK(o_rd_data, exp_w)
      `CHK(o_word_irq, i_word_irq_en)
      `CHK({o_d_out[3:1], o_d_oe}, {6'h00, i_lanes == LANES_1 && (i_pins != PINS_3 || i_write_en)})
      tx_msk = {128{1'b1}} >> (7'h7F - i_word_len_m1);
      if (o_d_oe[0] === 1'b1) `CHK(tx_cap & tx_msk, i_tx_word & tx_msk)
    end
    if (o_frame_irq === 1'b1) frame_irqs++;
  end

  // ==========================================================================
  // Frame driver
  task automatic run_frame(input int d, input int len, input int cnt, input int dl,
                           input qsfc_lanes_e ln, input qsfc_pins_e pn);
    int w;
    int n;
    int fi;
    int guard;
    logic [127:0] acc;
    w = (ln == LANES_4) ? 4 : ((ln == LANES_2) ? 2 : 1);
    n = (len + w - 1) / w;
    @(posedge i_core_clk);
    #1;
    i_serial_clock_divider_value = 8'(d);
    i_word_len_m1 = 7'(len - 1);
    i_word_count_m1 = 12'(cnt - 1);
    i_cs_to_data_delay_field = 2'(dl);
    i_lanes = ln;
    i_pins = pn;
    i_write_en = (pn != PINS_3) & 1'($random(seed));
    i_tx_word = {$random(seed), $random(seed), $random(seed), $random(seed)};
    {i_word_irq_en, i_frame_irq_en} = 2'($random(seed));
    for (int k = 0; k < cnt; k++) begin
      acc = '0;
      for (int j = 0; j < n * w; j++) acc = {acc[126:0], stream[(k * n * w + j) % 512]};
      exp_q.push_back(acc & ({128{1'b1}} >> (128 - len)));
    end
    fi = frame_irqs;
    i_start = 1'b1;
    @(posedge i_core_clk);
    #1;
    i_start = 1'b0;
    repeat (3) @(posedge i_core_clk);
    #1;
    i_start = 1'b1;
    @(posedge i_core_clk);
    #1;
    i_start = 1'b0;
    guard = 0;
    while (o_busy !== 1'b0 && guard < 40000) begin
      @(posedge i_core_clk);
      guard++;
    end
    if (guard >= 40000) begin
      mismatches++;
      print_verdict();
    end
    @(posedge i_core_clk);
    #1;
    `CHK(exp_q.size(), 0)
    `CHK(frame_irqs - fi, int'(i_frame_irq_en))
  endtask : run_frame

  // ==========================================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 16; i++) stream[i * 32 +: 32] = $random(seed);
    repeat (8) @(posedge i_core_clk);
    #1;
    i_reset_n = 1'b1;
    `CHK(o_cs_n, 1'b1)
    run_frame(3, 1, 4096, 0, LANES_1, PINS_4);
    for (int i = 0; i < 12; i++) begin
      run_frame(3 + i % 5, (i == 1) ? 128 : 1 + {$random(seed)} % 128, 1 + i % 3, i % 4,
                qsfc_lanes_e'(i % 3), qsfc_pins_e'((i / 3) % 3));
    end
    print_verdict();
  end
endmodule : tb

// ### hw/qsfc_clkgen.sv
// Purpose: Serial clock divider producing high phase and fall moments.
// Assumes: Divider value is stable while enabled.
// Notes:   Period is D+1 core cycles; zero runs as one.
`timescale 1ns/1ps

module qsfc_clkgen (
  input  wire logic  i_core_clk,
  input  wire logic  i_reset_n,
  qsfc_tick_if.gen   tick
);
  import qsfc_pkg::*;

  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] nxt_cnt;
  logic [DIV_W-1:0] div_eff;
  logic [DIV_W-1:0] hi_len;

  // ===========================================================================
  // Period counter
  always_comb begin
    div_eff = (tick.div == '0) ? DIV_ZERO_EFF : tick.div;
    hi_len  = DIV_W'(({1'b0, div_eff} + 9'h001) >> 1);
    if (!tick.en) begin
      nxt_cnt = '0;
    end else if (cnt_ff == div_eff) begin
      nxt_cnt = '0;
    end else begin
      nxt_cnt = cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign tick.high = tick.en && (cnt_ff < hi_len);
  assign tick.fall = tick.en && (cnt_ff == hi_len);

endmodule : qsfc_clkgen

// ### hw/qsfc_pkg.sv
// Purpose: Shared constants and types of the quad serial flash controller.
// Assumes: Core clock of 250 MHz; serial clock mode zero only.
// Notes:   Widths and reset values used by every file of the block but the synchroniser.

package qsfc_pkg;

  // ===========================================================================
  // Clock and timing
  localparam int CORE_PERIOD_PS = 4000;
  localparam int SCLK_MIN_NS    = 25;
  localparam int SCLK_MIN_CYC   = (SCLK_MIN_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int CS_LAG_PERIODS = 2;

  // ===========================================================================
  // Widths and limits
  localparam int WORD_BITS_MAX   = 128;
  localparam int FRAME_WORDS_MAX = 4096;
  localparam int DIV_W           = 8;
  localparam int LEN_W           = 7;
  localparam int CNT_W           = 12;
  localparam int DLY_W           = 2;
  localparam int BIT_W           = 8;

  localparam logic [DIV_W-1:0] DIV_ZERO_EFF = 8'h01;
  localparam logic [1:0]       LAG_INIT     = 2'(CS_LAG_PERIODS);

  // ===========================================================================
  // Reset values
  localparam logic             RST_CS_N  = 1'b1;
  localparam logic             RST_SCLK  = 1'b0;
  localparam logic [127:0]     RST_WORD  = 128'h0;

  // ===========================================================================
  // Modes
  typedef enum logic [1:0] {
    LANES_1 = 2'h0,
    LANES_2 = 2'h1,
    LANES_4 = 2'h2
  } qsfc_lanes_e;

  typedef enum logic [1:0] {
    PINS_3 = 2'h0,
    PINS_4 = 2'h1,
    PINS_6 = 2'h2
  } qsfc_pins_e;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_LEAD  = 5'b00010,
    ST_SETUP = 5'b00100,
    ST_XFER  = 5'b01000,
    ST_LAG   = 5'b10000
  } qsfc_state_e;

endpackage : qsfc_pkg

// ### hw/qsfc_sync.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps

module qsfc_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule : qsfc_sync

// ### hw/qsfc_tick_if.sv
// Purpose: Carrier between the controller core and its serial clock divider.
// Assumes: One core clock domain.
// Notes:   High and fall are combinational from the divider counter.
`timescale 1ns/1ps

interface qsfc_tick_if;
  import qsfc_pkg::*;

  logic             en;
  logic [DIV_W-1:0] div;
  logic             high;
  logic             fall;

  modport gen  (input en, input div, output high, output fall);
  modport user (output en, output div, input high, input fall);
endinterface : qsfc_tick_if

// ### hw/qsfc_top.sv
// Purpose: Quad serial flash controller core, mode zero, one to four lanes.
// Assumes: Configuration inputs are held stable from start to frame end.
// Notes:   Pin inputs pass a two-flop synchroniser before sampling.
`timescale 1ns/1ps

module qsfc_top #(
  parameter int WORD_BITS  = qsfc_pkg::WORD_BITS_MAX,
  parameter int FRAME_MAX  = qsfc_pkg::FRAME_WORDS_MAX
) (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_reset_n,
  // Control
  input  wire logic                          i_start,
  input  wire logic [qsfc_pkg::DIV_W-1:0]    i_serial_clock_divider_value,
  input  wire logic [qsfc_pkg::LEN_W-1:0]    i_word_len_m1,
  input  wire logic [qsfc_pkg::CNT_W-1:0]    i_word_count_m1,
  input  wire logic [qsfc_pkg::DLY_W-1:0]    i_cs_to_data_delay_field,
  input  wire qsfc_pkg::qsfc_lanes_e         i_lanes,
  input  wire qsfc_pkg::qsfc_pins_e          i_pins,
  input  wire logic                          i_write_en,
  input  wire logic [127:0]                  i_tx_word,
  input  wire logic                          i_word_irq_en,
  input  wire logic                          i_frame_irq_en,
  // Status and read data
  output logic                               o_busy,
  output logic [127:0]                       o_rd_data,
  output logic                               o_rd_valid,
  output logic                               o_word_irq,
  output logic                               o_frame_irq,
  // Serial pins
  output logic                               o_sclk,
  output logic                               o_cs_n,
  output logic [3:0]                         o_d_out,
  output logic [3:0]                         o_d_oe,
  input  wire logic [3:0]                    i_d_in
);
  import qsfc_pkg::*;

  // ===========================================================================
  // Elaboration checks
  if (WORD_BITS != WORD_BITS_MAX) begin : g_bad_word
    $error("WORD_BITS must equal the read port width");
  end
  if (FRAME_MAX < 1 || FRAME_MAX > (1 << CNT_W)) begin : g_bad_frame
    $error("FRAME_MAX out of counter range");
  end

  // ===========================================================================
  // State
  qsfc_state_e       state_ff,   nxt_state;
  logic              cs_n_ff,    nxt_cs_n;
  logic              oe_ff,      nxt_oe;
  logic              dout_ff,    nxt_dout;
  logic              sclk_ff,    nxt_sclk;
  logic [127:0]      tx_ff,      nxt_tx;
  logic [127:0]      rx_ff,      nxt_rx;
  logic [127:0]      rd_ff,      nxt_rd;
  logic [BIT_W-1:0]  bit_ff,     nxt_bit;
  logic [CNT_W-1:0]  word_ff,    nxt_word;
  logic [1:0]        ph_ff,      nxt_ph;
  logic              vld_ff,     nxt_vld;
  logic              wirq_ff,    nxt_wirq;
  logic              firq_ff,    nxt_firq;
  // Configuration captured at start
  logic [DIV_W-1:0]  div_ff,     nxt_div;
  logic [LEN_W-1:0]  len_ff,     nxt_len;
  logic [CNT_W-1:0]  cnt_ff,     nxt_cnt;
  logic [DLY_W-1:0]  dly_ff,     nxt_dly;
  qsfc_lanes_e       lanes_ff,   nxt_lanes;
  qsfc_pins_e        pins_ff,    nxt_pins;
  logic              wr_ff,      nxt_wr;
  logic              wie_ff,     nxt_wie;
  logic              fie_ff,     nxt_fie;

  logic [3:0]        d_sync;
  logic [BIT_W-1:0]  step;
  logic [3:0]        sample;
  logic [127:0]      rx_shift;
  logic [127:0]      tx_load;
  logic              word_end;
  logic              drive_d0;

  qsfc_tick_if tick ();

  // ===========================================================================
  // Submodules
  qsfc_clkgen u_clkgen (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .tick       (tick)
  );

  qsfc_sync #(.WIDTH(4)) u_sync (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_async    (i_d_in),
    .o_sync     (d_sync)
  );

  assign tick.en  = (state_ff != ST_IDLE);
  assign tick.div = div_ff;

  // ===========================================================================
  // Lane helpers
  always_comb begin
    tx_load = i_tx_word << (7'h7F - len_ff);  // Word MSB moved to bit 127
    case (lanes_ff)
      LANES_4: begin
        step     = 8'h04;
        sample   = d_sync;
        rx_shift = {rx_ff[123:0], d_sync};
      end
      LANES_2: begin
        step     = 8'h02;
        sample   = {2'h0, d_sync[1:0]};
        rx_shift = {rx_ff[125:0], d_sync[1:0]};
      end
      default: begin
        step     = 8'h01;
        sample   = {3'h0, (pins_ff == PINS_3) ? d_sync[0] : d_sync[1]};
        rx_shift = {rx_ff[126:0], sample[0]};
      end
    endcase
    word_end = ({1'b0, bit_ff} + {1'b0, step}) >= ({2'h0, len_ff} + 9'h001);
    // Shared line in 3-pin set only driven when writing
    drive_d0 = (lanes_ff == LANES_1) && ((pins_ff != PINS_3) || wr_ff);
  end

  // ===========================================================================
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cs_n  = cs_n_ff;
    nxt_oe    = oe_ff;
    nxt_dout  = dout_ff;
    nxt_tx    = tx_ff;
    nxt_rx    = rx_ff;
    nxt_rd    = rd_ff;
    nxt_bit   = bit_ff;
    nxt_word  = word_ff;
    nxt_ph    = ph_ff;
    nxt_vld   = 1'b0;
    nxt_wirq  = 1'b0;
    nxt_firq  = 1'b0;
    nxt_div   = div_ff;
    nxt_len   = len_ff;
    nxt_cnt   = cnt_ff;
    nxt_dly   = dly_ff;
    nxt_lanes = lanes_ff;
    nxt_pins  = pins_ff;
    nxt_wr    = wr_ff;
    nxt_wie   = wie_ff;
    nxt_fie   = fie_ff;
    // Clock only toggles while shifting, idles low otherwise
    nxt_sclk  = (state_ff == ST_XFER) && tick.high;

    case (state_ff)
      ST_IDLE: begin
        nxt_cs_n = RST_CS_N;
        nxt_oe   = 1'b0;
        if (i_start) begin
          nxt_state = ST_LEAD;
          nxt_div   = i_serial_clock_divider_value;
          nxt_len   = i_word_len_m1;
          nxt_cnt   = i_word_count_m1;
          nxt_dly   = i_cs_to_data_delay_field;
          nxt_lanes = i_lanes;
          nxt_pins  = i_pins;
          nxt_wr    = i_write_en;
          nxt_wie   = i_word_irq_en;
          nxt_fie   = i_frame_irq_en;
          nxt_word  = '0;
          nxt_bit   = '0;
          nxt_ph    = 2'h0;
        end
      end
      ST_LEAD: begin
        if (tick.fall) begin
          if (ph_ff == 2'h0) begin
            nxt_oe = drive_d0;
            nxt_ph = 2'h1;
          end else begin
            nxt_cs_n = 1'b0;
            nxt_ph   = 2'h0;
            if (dly_ff == 2'h0) begin
              nxt_state = ST_XFER;
              nxt_dout  = tx_load[127];
              nxt_tx    = tx_load << 1;
            end else begin
              nxt_state = ST_SETUP;
            end
          end
        end
      end
      ST_SETUP: begin
        if (tick.fall) begin
          if (ph_ff == (dly_ff - 2'h1)) begin
            nxt_state = ST_XFER;
            nxt_dout  = tx_load[127];
            nxt_tx    = tx_load << 1;
          end else begin
            nxt_ph = ph_ff + 2'h1;
          end
        end
      end
      ST_XFER: begin
        if (tick.fall) begin
          nxt_rx = rx_shift;
          if (word_end) begin
            nxt_rd   = rx_shift & ({128{1'b1}} >> (7'h7F - len_ff));
            nxt_vld  = 1'b1;
            nxt_wirq = wie_ff;
            nxt_bit  = '0;
            nxt_rx   = '0;
            if (word_ff == cnt_ff) begin
              nxt_state = ST_LAG;
              nxt_ph    = LAG_INIT;
            end else begin
              nxt_word = word_ff + 12'h001;
              nxt_dout = tx_load[127];
              nxt_tx   = tx_load << 1;
            end
          end else begin
            nxt_bit  = bit_ff + step;
            nxt_dout = tx_ff[127];
            nxt_tx   = tx_ff << 1;
          end
        end
      end
      ST_LAG: begin
        if (tick.fall) begin
          if (ph_ff == 2'h1) begin
            nxt_cs_n  = RST_CS_N;
            nxt_oe    = 1'b0;
            nxt_firq  = fie_ff;
            nxt_state = ST_IDLE;
            nxt_ph    = 2'h0;
          end else begin
            nxt_ph = ph_ff - 2'h1;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= ST_IDLE;
      cs_n_ff  <= RST_CS_N;
      oe_ff    <= 1'b0;
      dout_ff  <= 1'b0;
      sclk_ff  <= RST_SCLK;
      tx_ff    <= RST_WORD;
      rx_ff    <= RST_WORD;
      rd_ff    <= RST_WORD;
      bit_ff   <= '0;
      word_ff  <= '0;
      ph_ff    <= 2'h0;
      vld_ff   <= 1'b0;
      wirq_ff  <= 1'b0;
      firq_ff  <= 1'b0;
      div_ff   <= '0;
      len_ff   <= '0;
      cnt_ff   <= '0;
      dly_ff   <= '0;
      lanes_ff <= LANES_1;
      pins_ff  <= PINS_4;
      wr_ff    <= 1'b0;
      wie_ff   <= 1'b0;
      fie_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cs_n_ff  <= nxt_cs_n;
      oe_ff    <= nxt_oe;
      dout_ff  <= nxt_dout;
      sclk_ff  <= nxt_sclk;
      tx_ff    <= nxt_tx;
      rx_ff    <= nxt_rx;
      rd_ff    <= nxt_rd;
      bit_ff   <= nxt_bit;
      word_ff  <= nxt_word;
      ph_ff    <= nxt_ph;
      vld_ff   <= nxt_vld;
      wirq_ff  <= nxt_wirq;
      firq_ff  <= nxt_firq;
      div_ff   <= nxt_div;
      len_ff   <= nxt_len;
      cnt_ff   <= nxt_cnt;
      dly_ff   <= nxt_dly;
      lanes_ff <= nxt_lanes;
      pins_ff  <= nxt_pins;
      wr_ff    <= nxt_wr;
      wie_ff   <= nxt_wie;
      fie_ff   <= nxt_fie;
    end
  end

  // ===========================================================================
  // Outputs
  assign o_busy      = (state_ff != ST_IDLE);
  assign o_rd_data   = rd_ff;
  assign o_rd_valid  = vld_ff;
  assign o_word_irq  = wirq_ff;
  assign o_frame_irq = firq_ff;
  assign o_sclk      = sclk_ff;
  assign o_cs_n      = cs_n_ff;
  assign o_d_out     = {3'h0, dout_ff};
  assign o_d_oe      = {3'h0, oe_ff};

endmodule : qsfc_top
